// ==== hw/dfr_channel.sv ====
// Purpose: one weigh channel: averaging, vibration filter, setpoint relays, refill
// Assumes: SAMPLE_VLD pulses once per converter update with a raw weight
// Notes:   relay bit high = relay closed; every relay opens by default
//
// Operation
// R1: weight path carries 23 magnitude bits
// R2: conversion rate selectable, 95 or 145
// R3: two relays switched by target, preact
// R4: relays automatic or manual; setpoints anytime
// R5: opened relay stays open until new fill
// R6: five selectable vibration filter cutoffs
// R7: filter cutoff defaults to 1 Hz
// R8: automatic refill only in single-speed mode
// R9: second relay refills single, dribbles dual
// R10: bad refill configuration reports status -1
// R11: dispense end below start weight starts refill
// R12: refill stops at stop weight, re-enables dispense
// R13: auto refill: relay one dispenses, two refills
// R14: manual refill ends at stop-refill weight
// R15: stop command opens both relays
// R16: direct relay command ignores weight comparisons; a running fill still opens relays at setpoints
// R17: processor senses supply level in filler mode
// R18: filler mode meters two ingredients per channel
// R19: relays open after reset and by default
// R20: average over 1 to 255 samples
// R21: comparisons once per update, latest sample
// R22: manual refill ignored while refill active
`timescale 1ns/1ns
module dfr_channel
  import dfr_pkg::*;
#(
  parameter int unsigned W = WEIGHT_W   // weight width
) (
  input  wire logic                 CORE_CLK,
  input  wire logic                 SRST,
  input  wire logic                 SAMPLE_VLD,
  input  wire logic signed [W-1:0]  SAMPLE_WEIGHT,
  input  wire logic                 FAST_RATE,
  input  wire logic [2:0]           FILTER_SEL,
  input  wire logic                 FILTER_LOAD,
  input  wire logic [7:0]           AVG_COUNT,
  input  wire dfr_mode_e            FILL_MODE,
  input  wire logic                 AUTO_REFILL,
  input  wire dfr_setp_s            SETPOINTS,
  input  wire dfr_cmd_s             COMMAND,
  output logic [1:0]                RELAY,
  output logic signed [W-1:0]       WEIGHT_OUT,
  output logic [7:0]                CMD_STATUS,
  output logic [2:0]                FILTER_CUR,
  output logic                      RATE_FAST_CUR,
  output dfr_state_e                STATE
);
  // elaboration check: the datapath needs at least 23 magnitude bits plus sign,
  // and the averaging accumulator adds eight more bits on top of that
  if (W < 24 || W > 32) begin : g_bad_width
    $error("weight width must be 24..32");
  end

  // weights of shifts per cutoff code, larger shift = lower cutoff
  function automatic logic [3:0] filt_shift(input logic [2:0] sel);
    case (sel)
      FILT_7P50: filt_shift = 4'h1;
      FILT_3P50: filt_shift = 4'h2;
      FILT_1P00: filt_shift = 4'h4;
      FILT_0P50: filt_shift = 4'h5;
      FILT_0P25: filt_shift = 4'h6;
      default:   filt_shift = 4'h0;   // off
    endcase
  endfunction : filt_shift

  // ---- datapath state
  // the accumulator is eight bits wider than a sample so that
  // 255 full-scale samples cannot overflow before the divide
  logic signed [W+7:0] acc_ff;            // sample sum for averaging
  logic [7:0]          acc_n_ff;          // samples summed so far
  logic signed [W-1:0] filt_ff;           // filtered weight
  logic signed [W-1:0] avg_ff;            // latest averaged weight
  logic                upd_ff;            // new averaged weight this cycle
  // ---- configuration and sequence state
  logic [2:0]          filt_sel_ff;       // selected cutoff
  logic                fast_ff;           // selected rate
  dfr_state_e          state_ff;          // sequence state
  logic [1:0]          relay_ff;          // relay drive
  logic [1:0]          latch_open_ff;     // relays locked open for this fill
  logic [7:0]          status_ff;         // command status

  // ---- averaging count and filter step
  // a count of zero would divide by zero, so it is served as one
  wire logic [7:0]        avg_n    = (AVG_COUNT == 8'h00) ? 8'h01 : AVG_COUNT;
  wire logic [3:0]        shift    = filt_shift(filt_sel_ff);
  // every operand is cast signed: one unsigned concatenation would turn
  // the arithmetic shift into a logical one and wreck falling weights
  wire logic signed [W:0] diff     = $signed({SAMPLE_WEIGHT[W-1], SAMPLE_WEIGHT})
                                     - $signed({filt_ff[W-1], filt_ff});
  wire logic signed [W:0] filt_nx  = $signed({filt_ff[W-1], filt_ff}) + (diff >>> shift);
  wire logic signed [W+7:0] acc_nx = acc_ff + $signed({{8{filt_nx[W-1]}}, filt_nx[W-1:0]});
  // ---- configuration checks and setpoint comparisons
  wire logic              avg_done = SAMPLE_VLD && (acc_n_ff + 8'h01 >= avg_n);
  wire logic              bad_cfg  = AUTO_REFILL && (FILL_MODE != DFR_SINGLE);
  wire logic              auto_ok  = AUTO_REFILL && (FILL_MODE == DFR_SINGLE);
  wire logic              at_pre   = avg_ff >= SETPOINTS.target - SETPOINTS.preact;
  wire logic              at_tgt   = avg_ff >= SETPOINTS.target;
  wire logic              refilled = avg_ff >= SETPOINTS.stop_refill;
  wire logic              low      = avg_ff <= SETPOINTS.start_refill;
  // relays that a fill opens on this update: bit0 at preact,
  // bit1 with bit0 in single mode (refill relay) or at target otherwise
  wire logic [1:0]        open_now = {(FILL_MODE == DFR_SINGLE) ? at_pre : at_tgt,
                                      at_pre};                     // R9 R18
  // a fill is over once every relay it drives has opened
  wire logic              fill_end = at_pre && (FILL_MODE == DFR_SINGLE || at_tgt);

  // configuration, filter load of a code up to FILT_0P25 reaches its setting; reset gives 1 Hz
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      filt_sel_ff <= FILT_RST;   // R7
      fast_ff     <= 1'b0;
    end else begin
      fast_ff <= FAST_RATE;      // R2
      if (FILTER_LOAD && FILTER_SEL <= FILT_0P25) filt_sel_ff <= FILTER_SEL;   // R6
    end
  end

  // filter then average each converter sample
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      filt_ff  <= '0;
      acc_ff   <= '0;
      acc_n_ff <= 8'h00;
      avg_ff   <= '0;
      upd_ff   <= 1'b0;
    end else begin
      upd_ff <= avg_done;
      if (SAMPLE_VLD) begin
        filt_ff <= filt_nx[W-1:0];                                   // R6
        if (avg_done) begin
          avg_ff   <= W'(acc_nx / $signed({1'b0, avg_n}));           // R20 R1
          acc_ff   <= '0;
          acc_n_ff <= 8'h00;
        end else begin
          acc_ff   <= acc_nx;                                        // R20
          acc_n_ff <= acc_n_ff + 8'h01;
        end
      end
    end
  end

  // command status
  always_ff @(posedge CORE_CLK) begin
    if (SRST) status_ff <= STAT_OK;
    else status_ff <= bad_cfg ? STAT_BAD_CFG : STAT_OK;   // R10 R8
  end

  // sequence and relays
  // commands win over weight updates, in the order stop, direct,
  // manual refill, start fill; weight decisions run only on upd_ff
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      state_ff      <= DFR_IDLE;
      relay_ff      <= 2'b00;                                      // R19
      latch_open_ff <= 2'b00;
    end else if (COMMAND.stop) begin
      state_ff      <= DFR_IDLE;
      relay_ff      <= 2'b00;                                      // R15
    end else if (COMMAND.direct_relay_command) begin
      relay_ff      <= COMMAND.relay_value;                        // R16 R4
    end else if (COMMAND.manual_refill_command && state_ff != DFR_REFILL
                 && state_ff != DFR_MANUAL) begin                  // R22
      state_ff      <= DFR_MANUAL;                                 // R14
      relay_ff      <= 2'b10;
    end else if (COMMAND.start_fill && state_ff == DFR_IDLE) begin
      state_ff      <= DFR_FILL;
      relay_ff      <= 2'b11;                                      // R3
      latch_open_ff <= 2'b00;                                      // R5
    end else if (upd_ff) begin                                     // R21
      case (state_ff)
        DFR_FILL: begin
          // relay one shuts at preact; second at target, or with one in single
          // opened relays stay locked open for the rest of this fill
          latch_open_ff <= latch_open_ff | open_now;               // R5
          if (fill_end) begin
            // end of dispense: refill when low and auto refill is legal
            if (auto_ok && low) begin
              state_ff <= DFR_REFILL;                              // R11 R8
              relay_ff <= 2'b10;                                   // R13
            end else begin
              state_ff <= DFR_IDLE;
              relay_ff <= 2'b00;                                   // R3
            end
          end else begin
            // mask in this update's openings too, so none lags an update
            relay_ff <= relay_ff & ~(latch_open_ff | open_now);    // R5 R3
          end
        end
        // automatic and manual refill both end at the stop-refill weight
        DFR_REFILL, DFR_MANUAL: begin
          if (refilled) begin
            state_ff <= DFR_IDLE;                                  // R12 R14
            relay_ff <= 2'b00;
          end
        end
        // idle: weight updates change nothing
        default: state_ff <= DFR_IDLE;
      endcase
    end
  end

  // outputs straight from flops

  assign RELAY         = relay_ff;
  assign WEIGHT_OUT    = avg_ff;
  assign CMD_STATUS    = status_ff;
  assign FILTER_CUR    = filt_sel_ff;
  assign RATE_FAST_CUR = fast_ff;
  assign STATE         = state_ff;

  // ---- checks
  // properties sample on the rising clock and sleep during reset, except
  // the reset checks themselves, which look at the edge after SRST
  // stop always clears both relays
  a_stop_opens: assert property (@(posedge CORE_CLK) disable iff (SRST)
    COMMAND.stop |=> RELAY == 2'b00) else $error("stop left relay closed"); // R15
  a_direct_set: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (!COMMAND.stop && COMMAND.direct_relay_command) |=> RELAY == $past(COMMAND.relay_value))
    else $error("direct relay not applied"); // R16
  // bad refill setup is reported as -1
  a_status_neg: assert property (@(posedge CORE_CLK) disable iff (SRST)
    bad_cfg |=> CMD_STATUS == 8'hff) else $error("status not -1"); // R10
  // refill only entered from single-speed mode
  a_refill_mode: assert property (@(posedge CORE_CLK) disable iff (SRST)
    ($changed(STATE) && STATE == DFR_REFILL) |-> $past(FILL_MODE) == DFR_SINGLE)
    else $error("auto refill outside single mode"); // R8
  // refill ends at stop weight
  a_refill_end: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (upd_ff && state_ff == DFR_REFILL && refilled && !COMMAND.stop
     && !COMMAND.direct_relay_command) |=> STATE == DFR_IDLE && RELAY == 2'b00)
    else $error("refill did not stop"); // R12
  // a running manual refill is not restarted or left
  a_manual_ign: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (state_ff == DFR_MANUAL && !upd_ff && !COMMAND.stop && !COMMAND.direct_relay_command)
    |=> STATE == DFR_MANUAL) else $error("manual refill disturbed"); // R22
  // an opened dispense relay stays open
  a_latch_open: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (state_ff == DFR_FILL && latch_open_ff[0] && !COMMAND.direct_relay_command)
    |=> !RELAY[0]) else $error("opened relay closed again"); // R5
  // only legal cutoff codes are held
  a_filt_range: assert property (@(posedge CORE_CLK) disable iff (SRST)
    FILTER_CUR <= FILT_0P25) else $error("filter code out of range"); // R6
  // every finished average raises one update strobe
  a_avg_update: assert property (@(posedge CORE_CLK) disable iff (SRST)
    avg_done |=> upd_ff ##1 !upd_ff) else $error("average update missed"); // R21
  // reset leaves relays open and the sequence idle
  a_reset_open: assert property (@(posedge CORE_CLK)
    SRST |=> RELAY == 2'b00 && STATE == DFR_IDLE)
    else $error("relays not open after reset"); // R19
  // reset restores the 1 Hz cutoff
  a_filter_dflt: assert property (@(posedge CORE_CLK)
    SRST |=> FILTER_CUR == FILT_RST) else $error("filter default wrong"); // R7
  // the rate selection is echoed one cycle later
  a_rate_echo: assert property (@(posedge CORE_CLK) disable iff (SRST)
    1'b1 |=> RATE_FAST_CUR == $past(FAST_RATE)) else $error("rate not taken"); // R2
  // start fill from idle closes both relays
  a_start_close: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (COMMAND.start_fill && state_ff == DFR_IDLE && !COMMAND.stop
     && !COMMAND.direct_relay_command && !COMMAND.manual_refill_command)
    |=> RELAY == 2'b11 && STATE == DFR_FILL) else $error("fill not started"); // R3
  // a manual refill from a quiet state drives only the second relay
  a_manual_go: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (COMMAND.manual_refill_command && state_ff != DFR_REFILL && state_ff != DFR_MANUAL
     && !COMMAND.stop && !COMMAND.direct_relay_command)
    |=> RELAY == 2'b10 && STATE == DFR_MANUAL) else $error("manual refill not begun"); // R14
  // a manual refill ends by itself at the stop weight
  a_manual_end: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (upd_ff && state_ff == DFR_MANUAL && refilled && !COMMAND.stop
     && !COMMAND.direct_relay_command) |=> STATE == DFR_IDLE && RELAY == 2'b00)
    else $error("manual refill did not stop"); // R14
  // a low single-speed dispense end hands over to refill
  a_auto_refill: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (upd_ff && state_ff == DFR_FILL && fill_end && auto_ok && low && !COMMAND.stop
     && !COMMAND.direct_relay_command && !COMMAND.manual_refill_command)
    |=> STATE == DFR_REFILL && RELAY == 2'b10) else $error("refill not started"); // R11
  // dual speed: past preact but short of target the dispense relay opens and the fill runs on
  a_dual_dribble: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (upd_ff && state_ff == DFR_FILL && FILL_MODE == DFR_DUAL && at_pre && !at_tgt
     && !COMMAND.stop && !COMMAND.direct_relay_command && !COMMAND.manual_refill_command)
    |=> !RELAY[0] && STATE == DFR_FILL) else $error("dispense relay not opened"); // R9
  // the reported weight moves only when an average completes
  a_weight_hold: assert property (@(posedge CORE_CLK) disable iff (SRST)
    !avg_done |=> $stable(WEIGHT_OUT)) else $error("weight moved between averages"); // R21
endmodule : dfr_channel

// ==== hw/dfr_pkg.sv ====
// Purpose: shared constants and types for the dispense/fill relay control block
// Assumes: one clock, weight samples arrive as strobes from the converter path
// Notes:   relay level 1 means relay closed (valve open); 0 is the default open state
package dfr_pkg;
  localparam int unsigned WEIGHT_W       = 24;            // signed weight, 23 magnitude bits
  localparam int unsigned RESOLUTION_CNT = 8388608;       // counts per reading
  localparam int unsigned RATE_SLOW_UPS  = 95;            // updates per second, slow
  localparam int unsigned RATE_FAST_UPS  = 145;           // updates per second, fast
  localparam int unsigned AVG_MAX        = 255;           // largest averaging count
  localparam logic [7:0]  AVG_RST        = 8'h01;         // averaging count after reset
  localparam logic [2:0]  FILT_OFF       = 3'h0;          // filter codes
  localparam logic [2:0]  FILT_7P50      = 3'h1;
  localparam logic [2:0]  FILT_3P50      = 3'h2;
  localparam logic [2:0]  FILT_1P00      = 3'h3;
  localparam logic [2:0]  FILT_0P50      = 3'h4;
  localparam logic [2:0]  FILT_0P25      = 3'h5;
  localparam logic [2:0]  FILT_RST       = FILT_1P00;     // factory default cutoff
  localparam logic [7:0]  STAT_OK        = 8'h00;         // command status: good
  localparam logic [7:0]  STAT_BAD_CFG   = 8'hff;         // command status: -1

  // fill mode of a channel
  typedef enum logic [1:0] {
    DFR_SINGLE = 2'b00,   // single-speed dispense, second relay refills
    DFR_DUAL   = 2'b01,   // dual-speed dispense, second relay dribbles
    DFR_FILLER = 2'b10    // filler, two ingredients
  } dfr_mode_e;

  // channel sequence state
  typedef enum logic [1:0] {
    DFR_IDLE   = 2'b00,
    DFR_FILL   = 2'b01,
    DFR_REFILL = 2'b10,
    DFR_MANUAL = 2'b11
  } dfr_state_e;

  // setpoints, updatable at any time
  typedef struct packed {
    logic signed [WEIGHT_W-1:0] target;
    logic signed [WEIGHT_W-1:0] preact;
    logic signed [WEIGHT_W-1:0] start_refill;
    logic signed [WEIGHT_W-1:0] stop_refill;
  } dfr_setp_s;

  // one-cycle command pulses
  typedef struct packed {
    logic start_fill;
    logic stop;
    logic manual_refill_command;
    logic direct_relay_command;
    logic [1:0] relay_value;   // bit0 dispense_relay, bit1 second relay
  } dfr_cmd_s;
endpackage : dfr_pkg

// ==== tb/dfr_scale_model.sv ====
// Purpose: weigh scale stand-in, paces converter updates and grows weight while a valve is open
// Assumes: any closed relay feeds material into the weighed vessel
// Notes:   the sample bus shows the inverted weight between strobes, never a stale copy
`timescale 1ns/1ns
module dfr_scale_model
  import dfr_pkg::*;
#(
  parameter int unsigned PERIOD = 4,  // cycles per converter update
  parameter int          STEP   = 8   // counts added per update while feeding
) (
  input  wire logic                   CORE_CLK,
  input  wire logic                   SRST,
  input  wire logic [1:0]             RELAY,
  input  wire logic                   PRESET,
  output logic                        SAMPLE_VLD,
  output logic signed [WEIGHT_W-1:0]  SAMPLE_WEIGHT
);
  logic [7:0]                 div_ff;  // update pacing
  logic signed [WEIGHT_W-1:0] w_ff;    // vessel weight
  assign SAMPLE_VLD    = (div_ff == 8'(PERIOD - 1));
  assign SAMPLE_WEIGHT = SAMPLE_VLD ? w_ff : ~w_ff;
  // pacing counter and weight growth
  always_ff @(posedge CORE_CLK) begin
    if (SRST || PRESET) begin
      div_ff <= 8'h00;
      w_ff   <= '0;
    end else begin
      div_ff <= SAMPLE_VLD ? 8'h00 : div_ff + 8'h01;
      if (SAMPLE_VLD && RELAY != 2'b00) begin
        w_ff <= w_ff + WEIGHT_W'(STEP);
      end
    end
  end
endmodule : dfr_scale_model

// ==== tb/dfr_channel_test.sv ====
// Purpose: self-checking bench for one weigh channel
// Assumes: filter off and single-sample averaging during fill runs
// Notes:   random relay values and targets come from an xorshift seeded with 57
`timescale 1ns/1ns
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_errors++; \
  $display("BAD %0t got %h want %h", $time, a, e); end end
module dfr_channel_test;
  import dfr_pkg::*;
  logic clk, srst, fast, fload, auto, preset, vld, rate_cur;
  logic [2:0] fsel, filter_cur, exp_f;
  logic [7:0] avg, cmd_status;
  logic [1:0] relay;
  logic signed [WEIGHT_W-1:0] swt, weight_out;
  logic [31:0] seed;
  dfr_mode_e mode;
  dfr_state_e state;
  dfr_setp_s sp;
  dfr_cmd_s cmd;
  int n_errors, n_compared, i, m, a;
  dfr_channel u_dut (.CORE_CLK(clk), .SRST(srst), .SAMPLE_VLD(vld), .SAMPLE_WEIGHT(swt),
    .FAST_RATE(fast), .FILTER_SEL(fsel), .FILTER_LOAD(fload), .AVG_COUNT(avg),
    .FILL_MODE(mode), .AUTO_REFILL(auto), .SETPOINTS(sp), .COMMAND(cmd), .RELAY(relay),
    .WEIGHT_OUT(weight_out), .CMD_STATUS(cmd_status), .FILTER_CUR(filter_cur),
    .RATE_FAST_CUR(rate_cur), .STATE(state));
  dfr_scale_model u_scale (.CORE_CLK(clk), .SRST(srst), .RELAY(relay), .PRESET(preset),
    .SAMPLE_VLD(vld), .SAMPLE_WEIGHT(swt));
  // pseudo random source
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  // cutoff after a load: out-of-range codes keep the old one
  function automatic logic [2:0] filt_exp(input logic [2:0] c, input logic [2:0] p);
    return (c <= FILT_0P25) ? c : p;
  endfunction : filt_exp
  // status: auto refill outside single-speed mode is a bad setup
  function automatic logic [7:0] stat_exp(input int au, input int md);
    return (au != 0 && md != 0) ? STAT_BAD_CFG : STAT_OK;
  endfunction : stat_exp
  task automatic step();
    @(posedge clk);
    #1;
  endtask : step
  // one-cycle command pulse: 0 start, 1 stop, 2 manual refill, 3 direct
  task automatic issue(input int k, input logic [1:0] v);
    step();
    cmd = dfr_cmd_s'({k == 0, k == 1, k == 2, k == 3, v});
    step();
    cmd = '0;
  endtask : issue
  task automatic do_preset();
    preset = 1'b1;
    step();
    preset = 1'b0;
    repeat (10) step();
  endtask : do_preset
  task automatic wait_relay(input logic [1:0] v);
    for (int j = 0; j < 3000 && relay !== v; j++) step();
    if (relay !== v) begin
      n_errors++;
      $display("BAD %0t relay wait ran out", $time);
      report_and_stop();
    end
  endtask : wait_relay
  task automatic report_and_stop();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    {srst, fast, fload, auto, preset, fsel, avg} = {5'b10000, 3'h0, 8'h01};
    {mode, sp, cmd, seed} = {DFR_SINGLE, 96'h0, 6'h0, 32'h39};
    repeat (20) @(posedge clk);
    #1 srst = 1'b0;
    `CHK(relay, 2'b00)
    `CHK(filter_cur, FILT_RST)
    `CHK(state, DFR_IDLE)
    fast = 1'b1;
    step();
    `CHK(rate_cur, 1'b1)
    fast = 1'b0;
    step();
    `CHK(rate_cur, 1'b0)
    exp_f = FILT_RST;
    for (i = 7; i >= 0; i--) begin
      fsel = i[2:0];
      fload = 1'b1;
      step();
      fload = 1'b0;
      exp_f = filt_exp(fsel, exp_f);
      step();
      `CHK(filter_cur, exp_f)
    end
    for (m = 0; m < 3; m++) for (a = 0; a < 2; a++) begin
      {mode, auto} = {dfr_mode_e'(m[1:0]), a[0]};
      repeat (2) step();
      `CHK(cmd_status, stat_exp(a, m))
    end
    {mode, auto} = {DFR_DUAL, 1'b0};
    for (i = 0; i < 6; i++) begin
      seed = xs(seed);
      issue(3, seed[1:0]);
      `CHK(relay, seed[1:0])
      `CHK(state, DFR_IDLE)
    end
    issue(1, 2'b00);
    `CHK(relay, 2'b00)
    do_preset();
    sp.target = 24'sh0c8 + {18'h0, seed[5:0]};
    sp.preact = 24'sh028;
    issue(0, 2'b00);
    `CHK(relay, 2'b11)
    wait_relay(2'b10);
    `CHK(weight_out >= sp.target - sp.preact, 1'b1)
    sp.preact = 24'sh000;
    repeat (8) step();
    `CHK(relay[0], 1'b0)
    wait_relay(2'b00);
    `CHK(weight_out >= sp.target, 1'b1)
    {mode, auto} = {DFR_SINGLE, 1'b1};
    sp = {24'sh064, 24'sh014, 24'sh1f4, 24'sh12c};
    do_preset();
    issue(0, 2'b00);
    wait_relay(2'b10);
    `CHK(state, DFR_REFILL)
    wait_relay(2'b00);
    `CHK(weight_out >= sp.stop_refill, 1'b1)
    `CHK(state, DFR_IDLE)
    issue(0, 2'b00);
    `CHK(relay[0], 1'b1)
    issue(1, 2'b00);
    {mode, auto} = {DFR_FILLER, 1'b0};
    sp.stop_refill = 24'sh078;
    avg = 8'h04;
    do_preset();
    issue(2, 2'b00);
    `CHK(relay, 2'b10)
    repeat (6) step();
    issue(2, 2'b00);
    `CHK(state, DFR_MANUAL)
    wait_relay(2'b00);
    `CHK(weight_out >= sp.stop_refill, 1'b1)
    repeat (40) step();
    `CHK(weight_out, u_scale.w_ff)
    report_and_stop();
  end
endmodule : dfr_channel_test
